// [eivs_pkg.sv]
// Purpose: Shared constants for the external request and vector select block
// Assumes: Byte address of a register is four times its index
// Notes:   Block sizes, field codes and control register reset values live here
package eivs_pkg;
	// ----------------------------------------------------------------
	// Register indexes (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_FLAGS    = 8'h3C;
	localparam logic [7:0] IDX_MASK     = 8'h3D;
	localparam logic [7:0] IDX_CORE     = 8'h55;
	localparam logic [7:0] IDX_SENSE    = 8'h69;
	localparam logic [7:0] IDX_PC_MASK  = 8'h70;
	localparam logic [7:0] IDX_PC_EN    = 8'h71;
	localparam logic [7:0] IDX_PC_FLAGS = 8'h72;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int          N_EXT       = 3;
	localparam int          N_PC        = 32;
	localparam int          N_GRP       = 4;
	localparam int          CORE_UNLOCK = 0;
	localparam int          CORE_SELECT = 1;
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Sense codes and timing
	// ----------------------------------------------------------------
	localparam logic [1:0]  SENSE_LOW   = 2'h0;
	localparam logic [1:0]  SENSE_ANY   = 2'h1;
	localparam logic [1:0]  SENSE_FALL  = 2'h2;
	localparam logic [1:0]  SENSE_RISE  = 2'h3;
	localparam logic [2:0]  UNLOCK_CYC  = 3'h4;

	typedef enum logic [1:0] {VC_IDLE, VC_UNLOCKED, VC_HOLD} eivs_vc_t;
endpackage

// [eivs_sync.sv]
// Purpose: Two-stage synchroniser with edge detection for request pins
// Assumes: Inputs may change at any time relative to clk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module eivs_sync #(
	parameter int W = 3
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);
	logic [W-1:0] meta;
	logic [W-1:0] prev;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta    <= '1;
			level_o <= '1;
			prev    <= '1;
		end
		else
		begin
			meta    <= pin_i;
			level_o <= meta;
			prev    <= level_o;
		end
	end

	assign rise_o = level_o & ~prev;
	assign fall_o = ~level_o & prev;
endmodule // eivs_sync

// [eivs_top.sv]
// Purpose: External request pins, pin-change groups and vector table select
// Assumes: Classic Wishbone slave, 8-bit registers in the low byte lane except the 32-bit pin-change mask
// Notes:   Pins are sampled on clk_i; one ack per request, one wait cycle
//
// Overview of operation
// - Select bit zero puts the vector table at flash address zero.
// - Select bit one moves the table to the boot region base.
// - Requests masked from unlock set until the instruction after select write.
// - Without a select write, requests masked four cycles then released.
// - Automatic masking leaves the global enable bit untouched.
// - Unlock clears four cycles after being set, or on select write.
// - Boot lock blocks requests while running code in the other region.
// - Requests rise regardless of pin direction; software may toggle them.
// - Group g covers pin-change inputs 8g+7 down to 8g.
// - Pin-change detection needs no peripheral clock gating.
// - Low-level mode requests for as long as the pin stays low.
// - Sense field: low level, any edge, falling edge, rising edge.
// - Sense fields at 5:4, 3:2, 1:0; bits 7:6 read zero.
// - Pin request enabled only with its mask bit and global enable.
// - Edges are captured; pulses wider than minimum make a request.
// - A low level gone before wake-up completes makes no request.
// - Flag sets on trigger, clears on vector or write one, zero in level.
// - Pin-change input counts only with its mask and group enable set.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module eivs_top #(
	parameter int ADR_W       = 10,
	parameter int VA_W        = 16,
	parameter int FLASH_WORDS = 32768,
	parameter int BOOT_UNIT   = 512
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic [2:0]        ext_request_pins_i,
	input  wire logic [31:0]       pin_change_inputs_i,
	input  wire logic              status_word_ie_i,
	input  wire logic [2:0]        ext_vector_done_i,
	input  wire logic [3:0]        pc_vector_done_i,
	input  wire logic              instr_done_i,
	input  wire logic              in_boot_code_i,
	input  wire logic              app_side_boot_lock_i,
	input  wire logic              boot_side_boot_lock_i,
	input  wire logic [1:0]        boot_size_setting_i,
	output logic      [2:0]        ext_irq_o,
	output logic      [3:0]        pc_irq_o,
	output logic                   vector_table_select_o,
	output logic      [VA_W-1:0]   vector_base_o
);
	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [2:0]           ext_request_flag_bits;
	logic [2:0]           ext_request_mask;
	logic [5:0]           ext_sense_control;
	logic [3:0]           core_upper;
	logic [31:0]          pin_change_mask;
	logic [3:0]           pin_change_group_enable;
	logic [3:0]           pc_flags;
	eivs_pkg::eivs_vc_t   vc_state;
	eivs_pkg::eivs_vc_t   next_vc_state;
	logic [2:0]           unlock_cnt;
	logic [2:0]           next_unlock_cnt;
	logic [2:0]           ext_lvl;
	logic [2:0]           ext_rise;
	logic [2:0]           ext_fall;
	logic [31:0]          pc_rise;
	logic [31:0]          pc_fall;
	logic [2:0]           ext_trig;
	logic [2:0]           ext_req;
	logic [3:0]           pc_trig;
	logic [31:0]          rdata;
	logic [VA_W-1:0]      boot_base;
	logic                 vector_change_unlock;
	logic                 next_auto_mask;
	logic                 blocked;
	logic                 gate;
	logic                 acc;
	logic                 wr;
	logic [7:0]           idx;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Clocked capture trades true sleep wake-up for a glitch-free core side
	eivs_sync #(.W(eivs_pkg::N_EXT)) u_ext_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (ext_request_pins_i),
		.level_o(ext_lvl),
		.rise_o (ext_rise),
		.fall_o (ext_fall)
	);

	eivs_sync #(.W(eivs_pkg::N_PC)) u_pc_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (pin_change_inputs_i),
		.level_o(),
		.rise_o (pc_rise),
		.fall_o (pc_fall)
	);

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	assign acc = wb_cyc_i & wb_stb_i;
	assign wr  = acc & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign idx = wb_adr_i[9:2];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= eivs_pkg::RST_WORD;
		end
		else
		begin
			wb_ack_o <= acc & ~wb_ack_o;
			wb_dat_o <= rdata;
		end
	end

	always_comb
	begin
		rdata = eivs_pkg::RST_WORD;
		case (idx)
			eivs_pkg::IDX_FLAGS:    rdata[2:0] = ext_request_flag_bits;
			eivs_pkg::IDX_MASK:     rdata[2:0] = ext_request_mask;
			eivs_pkg::IDX_CORE:     rdata[7:0] = {core_upper, 2'h0,
				vector_table_select_o, vector_change_unlock};
			eivs_pkg::IDX_SENSE:    rdata[5:0] = ext_sense_control;
			eivs_pkg::IDX_PC_MASK:  rdata      = pin_change_mask;
			eivs_pkg::IDX_PC_EN:    rdata[3:0] = pin_change_group_enable;
			eivs_pkg::IDX_PC_FLAGS: rdata[3:0] = pc_flags;
			default:                rdata      = eivs_pkg::RST_WORD;
		endcase
	end

	// ----------------------------------------------------------------
	// Plain control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ext_request_mask        <= eivs_pkg::RST_BYTE[2:0];
			ext_sense_control       <= eivs_pkg::RST_BYTE[5:0];
			core_upper              <= eivs_pkg::RST_BYTE[3:0];
			pin_change_group_enable <= eivs_pkg::RST_BYTE[3:0];
		end
		else if (wr)
		begin
			if (idx == eivs_pkg::IDX_MASK)
				ext_request_mask <= wb_dat_i[2:0];
			if (idx == eivs_pkg::IDX_SENSE)
				ext_sense_control <= wb_dat_i[5:0];
			if (idx == eivs_pkg::IDX_CORE)
				core_upper <= wb_dat_i[7:4];
			if (idx == eivs_pkg::IDX_PC_EN)
				pin_change_group_enable <= wb_dat_i[3:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pin_change_mask <= eivs_pkg::RST_WORD;
		else if (acc & wb_we_i & wb_ack_o & (idx == eivs_pkg::IDX_PC_MASK))
		begin
			for (int b = 0; b < 4; b++)
				if (wb_sel_i[b])
					pin_change_mask[8*b +: 8] <= wb_dat_i[8*b +: 8];
		end
	end

	// ----------------------------------------------------------------
	// Vector select unlock sequence
	// ----------------------------------------------------------------
	always_comb
	begin
		next_vc_state   = vc_state;
		next_unlock_cnt = unlock_cnt;
		case (vc_state)
			eivs_pkg::VC_IDLE:
			begin
				if (wr && idx == eivs_pkg::IDX_CORE
					&& wb_dat_i[eivs_pkg::CORE_UNLOCK])
				begin
					next_vc_state   = eivs_pkg::VC_UNLOCKED;
					next_unlock_cnt = eivs_pkg::UNLOCK_CYC - 3'h1;
				end
			end
			eivs_pkg::VC_UNLOCKED:
			begin
				if (wr && idx == eivs_pkg::IDX_CORE
					&& !wb_dat_i[eivs_pkg::CORE_UNLOCK])
					next_vc_state = eivs_pkg::VC_HOLD;
				else if (unlock_cnt == 3'h0)
					next_vc_state = eivs_pkg::VC_IDLE;
				else
					next_unlock_cnt = unlock_cnt - 3'h1;
			end
			eivs_pkg::VC_HOLD:
			begin
				if (instr_done_i)
					next_vc_state = eivs_pkg::VC_IDLE;
			end
			default: next_vc_state = eivs_pkg::VC_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			vc_state              <= eivs_pkg::VC_IDLE;
			unlock_cnt            <= 3'h0;
			vector_table_select_o <= 1'b0;
		end
		else
		begin
			vc_state   <= next_vc_state;
			unlock_cnt <= next_unlock_cnt;
			// Select only moves inside the unlock window
			if (vc_state == eivs_pkg::VC_UNLOCKED
				&& next_vc_state == eivs_pkg::VC_HOLD)
				vector_table_select_o <= wb_dat_i[eivs_pkg::CORE_SELECT];
		end
	end

	assign vector_change_unlock = (vc_state == eivs_pkg::VC_UNLOCKED);
	// Mask starts in the same cycle unlock reads as set
	assign next_auto_mask = (next_vc_state != eivs_pkg::VC_IDLE);

	// ----------------------------------------------------------------
	// Vector table placement
	// ----------------------------------------------------------------
	assign boot_base = VA_W'(FLASH_WORDS
		- (BOOT_UNIT << (3 - int'(boot_size_setting_i))));
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			vector_base_o <= '0;
		else if (vector_table_select_o)
			vector_base_o <= boot_base;
		else
			vector_base_o <= '0;
	end

	// ----------------------------------------------------------------
	// External request pins
	// ----------------------------------------------------------------
	genvar n;
	generate
		for (n = 0; n < eivs_pkg::N_EXT; n++)
		begin : g_ext
			logic [1:0] sense;
			assign sense = ext_sense_control[2*n +: 2];
			always_comb
			begin
				case (sense)
					eivs_pkg::SENSE_ANY:  ext_trig[n] = ext_rise[n] | ext_fall[n];
					eivs_pkg::SENSE_FALL: ext_trig[n] = ext_fall[n];
					eivs_pkg::SENSE_RISE: ext_trig[n] = ext_rise[n];
					default:              ext_trig[n] = 1'b0;
				endcase
			end
			// Level mode follows the live pin, so a level gone early asks nothing
			assign ext_req[n] = (sense == eivs_pkg::SENSE_LOW) ? ~ext_lvl[n]
				: ext_request_flag_bits[n];

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					ext_request_flag_bits[n] <= 1'b0;
				else if (sense == eivs_pkg::SENSE_LOW)
					ext_request_flag_bits[n] <= 1'b0;
				else if (ext_trig[n])
					ext_request_flag_bits[n] <= 1'b1;
				else if (ext_vector_done_i[n]
					|| (wr && idx == eivs_pkg::IDX_FLAGS && wb_dat_i[n]))
					ext_request_flag_bits[n] <= 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pin-change groups
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < eivs_pkg::N_GRP; g++)
		begin : g_pc
			assign pc_trig[g] = pin_change_group_enable[g]
				& |((pc_rise[8*g +: 8] | pc_fall[8*g +: 8])
				& pin_change_mask[8*g +: 8]);

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					pc_flags[g] <= 1'b0;
				else if (pc_trig[g])
					pc_flags[g] <= 1'b1;
				else if (pc_vector_done_i[g]
					|| (wr && idx == eivs_pkg::IDX_PC_FLAGS && wb_dat_i[g]))
					pc_flags[g] <= 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Request outputs
	// ----------------------------------------------------------------
	assign blocked = (vector_table_select_o & app_side_boot_lock_i
		& ~in_boot_code_i) | (~vector_table_select_o
		& boot_side_boot_lock_i & in_boot_code_i);
	// Status word enable is only read here, never written back
	assign gate = status_word_ie_i & ~next_auto_mask & ~blocked;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ext_irq_o <= 3'h0;
			pc_irq_o  <= 4'h0;
		end
		else
		begin
			ext_irq_o <= ext_req & ext_request_mask & {3{gate}};
			pc_irq_o  <= pc_flags & pin_change_group_enable & {4{gate}};
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_UNLOCK_CLR: assert property (@(posedge clk_i)
		disable iff (rst_i)
		$rose(vector_change_unlock) |-> ##[1:4] !vector_change_unlock)
		else $error("unlock bit held past four cycles");

	AST_AUTO_MASK: assert property (@(posedge clk_i)
		disable iff (rst_i)
		$rose(vector_change_unlock) |=> (ext_irq_o == 3'h0)
		&& (pc_irq_o == 4'h0))
		else $error("request seen while unlock window open");

	AST_MASK_RELEASE: assert property (@(posedge clk_i)
		disable iff (rst_i)
		vector_change_unlock && unlock_cnt == 3'h0 && !wr
		|=> vc_state == eivs_pkg::VC_IDLE)
		else $error("mask not released after four cycles");

	// Base is registered, so it follows select one cycle later
	AST_BASE_LOW: assert property (@(posedge clk_i)
		disable iff (rst_i)
		!vector_table_select_o |=> vector_base_o == '0)
		else $error("vector base not zero with select clear");

	AST_BASE_BOOT: assert property (@(posedge clk_i)
		disable iff (rst_i)
		vector_table_select_o |=> vector_base_o == VA_W'(FLASH_WORDS
		- BOOT_UNIT * (8 >> $past(boot_size_setting_i))))
		else $error("vector base not at boot region");

	AST_RSVD_ZERO: assert property (@(posedge clk_i)
		disable iff (rst_i)
		wb_ack_o && $past(idx) == eivs_pkg::IDX_SENSE
		|-> wb_dat_o[7:6] == 2'h0)
		else $error("sense reserved bits not zero");

	AST_LEVEL_REQ: assert property (@(posedge clk_i)
		disable iff (rst_i)
		ext_sense_control[1:0] == eivs_pkg::SENSE_LOW && !ext_lvl[0]
		&& ext_request_mask[0] && gate |=> ext_irq_o[0])
		else $error("low level did not request");

	AST_LEVEL_FLAG: assert property (@(posedge clk_i)
		disable iff (rst_i)
		ext_sense_control[1:0] == eivs_pkg::SENSE_LOW
		&& $past(ext_sense_control[1:0]) == eivs_pkg::SENSE_LOW
		|-> !ext_request_flag_bits[0])
		else $error("flag set in level mode");

	AST_GIE: assert property (@(posedge clk_i)
		disable iff (rst_i)
		!status_word_ie_i |=> ext_irq_o == 3'h0 && pc_irq_o == 4'h0)
		else $error("request with global enable clear");

	AST_BLOCK: assert property (@(posedge clk_i)
		disable iff (rst_i)
		blocked |=> ext_irq_o == 3'h0 && pc_irq_o == 4'h0)
		else $error("request while boot lock blocks");

	AST_GRP_EN: assert property (@(posedge clk_i)
		disable iff (rst_i)
		!pin_change_group_enable[3] |=> !pc_irq_o[3])
		else $error("group three request while disabled");
endmodule // eivs_top

// [eivs_pin_model.sv]
// Purpose: Board-side model driving request and pin-change pins
// Assumes: Levels change only just after a rising clk_i edge
// Notes:   slow_i adds a cycle of lag, as a sluggish board driver would
`timescale 1ns/1ps
module eivs_pin_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        slow_i,
	input  wire logic [34:0] want_i,
	output logic      [2:0]  ext_o,
	output logic      [31:0] pc_o
);
	logic [34:0] lag;
	logic [34:0] drive;

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	// Pins idle high like pulled-up lines; levels held whole cycles
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			lag   <= '1;
			drive <= '1;
		end
		else
		begin
			lag   <= want_i;
			drive <= slow_i ? lag : want_i;
		end
	end

	assign ext_o = drive[2:0];
	assign pc_o  = drive[34:3];
endmodule // eivs_pin_model

// [tb.sv]
// Purpose: Self-checking bench for the request and vector select block
// Assumes: One wait cycle Wishbone slave, pins idle high
// Notes:   Random draws come from an 8-bit shift register seeded at 93
`timescale 1ns/1ps
module tb;
	logic        clk_i = 1'b0, rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [9:0]  wb_adr_i = '0;
	logic [3:0]  wb_sel_i = '0, pc_vector_done_i = '0, pc_irq_o;
	logic [31:0] wb_dat_i = '0, wb_dat_o, pin_change_inputs_i, q, m;
	logic        wb_ack_o, status_word_ie_i = 1'b0, instr_done_i = 1'b0;
	logic        in_boot_code_i = 1'b0, app_side_boot_lock_i = 1'b0;
	logic        boot_side_boot_lock_i = 1'b0, slow = 1'b0, e;
	logic [1:0]  boot_size_setting_i = '0;
	logic [2:0]  ext_vector_done_i = '0, ext_request_pins_i, ext_irq_o;
	logic        vector_table_select_o;
	logic [15:0] vector_base_o;
	logic [34:0] want = '1;
	logic [7:0]  lfsr = 8'h5D, r8;
	logic [4:0]  p;
	int          fail_count = 0, n_tests = 0;

	always #50 clk_i = ~clk_i;

	eivs_top i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.ext_request_pins_i, .pin_change_inputs_i, .status_word_ie_i,
		.ext_vector_done_i, .pc_vector_done_i, .instr_done_i,
		.in_boot_code_i, .app_side_boot_lock_i, .boot_side_boot_lock_i,
		.boot_size_setting_i, .ext_irq_o, .pc_irq_o,
		.vector_table_select_o, .vector_base_o);
	eivs_pin_model i_pins (.clk_i, .rst_i, .slow_i(slow), .want_i(want),
		.ext_o(ext_request_pins_i), .pc_o(pin_change_inputs_i));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Never assumes a latency: waits for ack under a bound
	task automatic wb(input logic w, input logic [7:0] i,
		input logic [31:0] d, output logic [31:0] r);
		int k = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= {i, 2'h0};
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (wb_ack_o !== 1'b1 && k < 20);
		if (k >= 20)
			fail_count++;
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		logic [31:0] x;
		wb(1'b1, i, d, x);
	endtask

	task automatic rd(input logic [7:0] i, output logic [31:0] r);
		wb(1'b0, i, 32'h0, r);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic instr_pulse();
		instr_done_i <= 1'b1;
		@(posedge clk_i);
		instr_done_i <= 1'b0;
		tick(2);
	endtask

	task automatic rnd(output logic [7:0] r);
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		r = lfsr;
	endtask

	function automatic logic exp_req(input logic [1:0] md, input logic f);
		case (md)
			eivs_pkg::SENSE_ANY: return 1'b1;
			eivs_pkg::SENSE_RISE: return !f;
			default: return f;
		endcase
	endfunction

	function automatic logic [15:0] exp_base(input logic s, logic [1:0] b);
		return s ? 16'(32768 - (512 << (3 - b))) : 16'h0000;
	endfunction

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		tick(3);
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10, q);
		chk(q, 32'h0);
		for (int i = 0; i < 6; i++)
		begin
			rnd(r8);
			wr(eivs_pkg::IDX_SENSE, {24'h0, r8});
			rd(eivs_pkg::IDX_SENSE, q);
			chk(q, {24'h0, r8 & 8'h3F});
			wr(eivs_pkg::IDX_MASK, {24'h0, r8});
			rd(eivs_pkg::IDX_MASK, q);
			chk(q, {24'h0, r8 & 8'h07});
			wr(eivs_pkg::IDX_CORE, {24'h0, r8 & 8'hFE});
			rd(eivs_pkg::IDX_CORE, q);
			chk(q, {24'h0, r8 & 8'hF0});
		end
		$display("register test done");
		status_word_ie_i <= 1'b1;
		for (int n = 0; n < 3; n++)
			for (int md = 0; md < 4; md++)
			begin
				rnd(r8);
				slow <= r8[0];
				wr(eivs_pkg::IDX_MASK, 32'h0);
				wr(eivs_pkg::IDX_SENSE, 32'(md) << (2 * n));
				wr(eivs_pkg::IDX_FLAGS, 32'h7);
				wr(eivs_pkg::IDX_MASK, 32'h1 << n);
				want[n] <= 1'b0;
				tick(7);
				e = exp_req(2'(md), 1'b1);
				chk(ext_irq_o[n], e);
				rd(eivs_pkg::IDX_FLAGS, q);
				chk(q, 32'(e && md != 0) << n);
				status_word_ie_i <= 1'b0;
				tick(2);
				chk(ext_irq_o, 3'h0);
				status_word_ie_i <= 1'b1;
				wr(eivs_pkg::IDX_FLAGS, 32'h1 << n);
				tick(2);
				chk(ext_irq_o[n], md == 0);
				want[n] <= 1'b1;
				tick(7);
				chk(ext_irq_o[n], exp_req(2'(md), 1'b0));
				ext_vector_done_i[n] <= 1'b1;
				@(posedge clk_i);
				ext_vector_done_i <= 3'h0;
				tick(2);
				chk(ext_irq_o[n], 1'b0);
			end
		$display("sense test done");
		for (int i = 0; i < 8; i++)
		begin
			for (int b = 0; b < 4; b++)
			begin
				rnd(r8);
				m = {m[23:0], r8};
			end
			rnd(r8);
			p = r8[4:0];
			// Fresh draw, else the group enable shares a bit with p
			rnd(r8);
			wr(eivs_pkg::IDX_PC_MASK, m);
			wr(eivs_pkg::IDX_PC_EN, {28'h0, r8[7:4]});
			want[3 + p] <= ~want[3 + p];
			tick(7);
			e = m[p] & r8[4 + p[4:3]];
			chk(pc_irq_o, 4'(e) << p[4:3]);
			rd(eivs_pkg::IDX_PC_FLAGS, q);
			chk(q, 32'(e) << p[4:3]);
			pc_vector_done_i <= 4'hF;
			@(posedge clk_i);
			pc_vector_done_i <= 4'h0;
			tick(2);
			chk(pc_irq_o, 4'h0);
		end
		$display("pin change test done");
		rnd(r8);
		boot_size_setting_i <= r8[1:0];
		wr(eivs_pkg::IDX_MASK, 32'h1);
		wr(eivs_pkg::IDX_SENSE, 32'h0);
		want[0] <= 1'b0;
		tick(6);
		chk(vector_base_o, exp_base(1'b0, r8[1:0]));
		wr(eivs_pkg::IDX_CORE, 32'h1);
		@(posedge clk_i);
		chk(ext_irq_o, 3'h0);
		tick(6);
		chk(ext_irq_o[0], 1'b1);
		rd(eivs_pkg::IDX_CORE, q);
		chk(q[1:0], 2'h0);
		wr(eivs_pkg::IDX_CORE, 32'h1);
		wr(eivs_pkg::IDX_CORE, 32'h2);
		tick(3);
		chk(vector_table_select_o, 1'b1);
		chk(vector_base_o, exp_base(1'b1, r8[1:0]));
		chk(ext_irq_o, 3'h0);
		instr_pulse();
		chk(ext_irq_o[0], 1'b1);
		app_side_boot_lock_i <= 1'b1;
		tick(2);
		chk(ext_irq_o, 3'h0);
		in_boot_code_i <= 1'b1;
		tick(2);
		chk(ext_irq_o[0], 1'b1);
		wr(eivs_pkg::IDX_CORE, 32'h0);
		tick(2);
		chk(vector_table_select_o, 1'b1);
		wr(eivs_pkg::IDX_CORE, 32'h1);
		wr(eivs_pkg::IDX_CORE, 32'h0);
		boot_side_boot_lock_i <= 1'b1;
		instr_pulse();
		chk(vector_base_o, 16'h0000);
		chk(ext_irq_o, 3'h0);
		in_boot_code_i <= 1'b0;
		tick(2);
		chk(ext_irq_o[0], 1'b1);
		$display("vector select test done");
		finish_test();
	end

	// Whole run needs under a thousand cycles
	initial
	begin
		repeat (30000) @(posedge clk_i);
		fail_count++;
		finish_test();
	end
endmodule // tb
